// ### verilog/ssob_pkg.sv
// package: register map, field layouts and enables for the supply signal override bank
package ssob_pkg;
    // printed offsets are register indices; byte address is four times the index
    localparam logic [7:0]  IDX_REG_STATUS  = 8'hE1;
    localparam logic [7:0]  IDX_CHARGER     = 8'hE2;
    localparam logic [7:0]  IDX_MISC        = 8'hE3;
    localparam logic [7:0]  IDX_CONV_OV     = 8'hE4;
    localparam logic [7:0]  IDX_CONV_UV     = 8'hE5;
    localparam logic [7:0]  IDX_FORCE_CTRL  = 8'hF0;
    localparam int          WORD_SHIFT      = 2;
    localparam int          ADDR_W          = 10;
    localparam int          NUM_REGS        = 5;

    // implemented bits of each register
    localparam logic [15:0] MASK_REG_STATUS = 16'h8F3F;
    localparam logic [15:0] MASK_CHARGER    = 16'hC807;
    localparam logic [15:0] MASK_MISC       = 16'h34FE;
    localparam logic [15:0] MASK_CONV_OV    = 16'h002D;
    localparam logic [15:0] MASK_CONV_UV    = 16'h8F3F;
    localparam logic [15:0] MASK_OC_BIT     = 16'h8000;
    localparam logic [15:0] MASK_UV_BITS    = 16'h0F3F;
    localparam logic [15:0] RESET_VALUE     = 16'h0000;

    // force control register bits
    localparam int          BIT_GENERAL_EN  = 0;
    localparam int          BIT_OV_EN       = 1;
    localparam int          BIT_OC_EN       = 2;
    localparam int          BIT_UV_EN       = 3;
    localparam logic [3:0]  MASK_FORCE_CTRL = 4'hF;

    // ahb transfer codes
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
    localparam logic [1:0]  HRESP_OKAY      = 2'h0;
endpackage

// ### verilog/ssob_mux_if.sv
// interface: written values and enables passed to the substitution mux
interface ssob_mux_if;
    import ssob_pkg::*;
    logic [15:0] wr_val [NUM_REGS];
    logic [15:0] raw    [NUM_REGS];
    logic [15:0] deb    [NUM_REGS];
    logic [3:0]  force_en;
    modport bank (output wr_val, output raw, output force_en, input deb);
    modport mux  (input wr_val, input raw, input force_en, output deb);
endinterface

// ### verilog/ssob_force_mux.sv
// module: picks written or analog value per bit for the debounce inputs
module ssob_force_mux
    import ssob_pkg::*;
(
    ssob_mux_if.mux m
);
    // select mask per register from the enables
    function automatic logic [15:0] pick(input logic [15:0] w, input logic [15:0] r,
                                          input logic [15:0] sel);
        pick = (w & sel) | (r & ~sel);
    endfunction

    logic [15:0] sel_uv;
    logic [15:0] sel_gen;

    // group enables; a clear enable leaves the analog value through
    always_comb begin
        sel_gen = m.force_en[BIT_GENERAL_EN] ? 16'hFFFF : 16'h0000;
        sel_uv  = (m.force_en[BIT_UV_EN] ? MASK_UV_BITS : 16'h0000)
                | (m.force_en[BIT_OC_EN] ? MASK_OC_BIT : 16'h0000);
        m.deb[0] = pick(m.wr_val[0], m.raw[0], sel_gen & MASK_REG_STATUS);
        m.deb[1] = pick(m.wr_val[1], m.raw[1], sel_gen & MASK_CHARGER);
        m.deb[2] = pick(m.wr_val[2], m.raw[2], sel_gen & MASK_MISC);
        m.deb[3] = pick(m.wr_val[3], m.raw[3],
                        m.force_en[BIT_OV_EN] ? MASK_CONV_OV : 16'h0000);
        m.deb[4] = pick(m.wr_val[4], m.raw[4], sel_uv);
    end
endmodule

// ### verilog/ssob_bank.sv
// module: supply signal override bank with ahb-lite register access
//
// Contract
// - reads return raw undebounced analog signal values
// - general enable substitutes status, charger, misc bits
// - over-voltage enable substitutes converter over-voltage bits
// - over-current enable substitutes limit switch bit
// - under-voltage enable substitutes regulator under-voltage bits
// - sequencer reset clears regulator status bits
// - status: switch 15, linear 11:8, converters 5:0
// - charger: hot 15, cold 14, end 11, thresholds 2:0
// - misc: sinks 13:12, usb limit 10, aux 7:4
// - misc: lockout ok 3, die temperature 2:1
// - over-voltage: converters 6,4,3,1 at 5,3,2,0
// - under-voltage: switch 15, linear 11:8, converters 5:0
//
// The AHB-Lite interface to the registers was chosen for this implementation.
module ssob_bank
    import ssob_pkg::*;
(
    input  wire logic              clk_sys_in,
    input  wire logic              rst_n_in,
    input  wire logic              clk_en_in,
    input  wire logic              seq_reset_in,
    input  wire logic              hsel_in,
    input  wire logic [31:0]       haddr_in,
    input  wire logic [1:0]        htrans_in,
    input  wire logic              hwrite_in,
    input  wire logic [2:0]        hsize_in,
    input  wire logic [31:0]       hwdata_in,
    input  wire logic              hready_in,
    output logic      [31:0]       hrdata_out,
    output logic                   hreadyout_out,
    output logic      [1:0]        hresp_out,
    input  wire logic [15:0]       raw_reg_status_in,
    input  wire logic [15:0]       raw_charger_in,
    input  wire logic [15:0]       raw_misc_in,
    input  wire logic [15:0]       raw_conv_ov_in,
    input  wire logic [15:0]       raw_conv_uv_in,
    output logic      [15:0]       deb_reg_status_out,
    output logic      [15:0]       deb_charger_out,
    output logic      [15:0]       deb_misc_out,
    output logic      [15:0]       deb_conv_ov_out,
    output logic      [15:0]       deb_conv_uv_out
);
    typedef struct packed {
        logic [NUM_REGS-1:0][15:0] raw_s1;
        logic [NUM_REGS-1:0][15:0] raw_s2;
        logic [NUM_REGS-1:0][15:0] wr_val;
        logic [3:0]                force_en;
        logic                      seq_s1;
        logic                      seq_s2;
        logic                      wr_pend;
        logic [7:0]                wr_idx;
        logic [31:0]               rdata;
        logic [NUM_REGS-1:0][15:0] deb;
    } ssob_state_t;

    ssob_state_t st_r;
    ssob_state_t st_nxt;
    ssob_mux_if  mif ();

    // maps a register index to its slot, or NUM_REGS for none
    function automatic int slot_of(input logic [7:0] idx);
        if (idx >= IDX_REG_STATUS && idx <= IDX_CONV_UV)
            slot_of = int'(idx - IDX_REG_STATUS);
        else
            slot_of = NUM_REGS;
    endfunction

    function automatic logic [15:0] mask_of(input int s);
        unique case (s)
            0:       mask_of = MASK_REG_STATUS;
            1:       mask_of = MASK_CHARGER;
            2:       mask_of = MASK_MISC;
            3:       mask_of = MASK_CONV_OV;
            4:       mask_of = MASK_CONV_UV;
            default: mask_of = 16'h0000;
        endcase
    endfunction

    logic [7:0] a_idx;
    logic       a_take;
    logic [15:0] raw_pin [NUM_REGS];

    assign raw_pin[0] = raw_reg_status_in;
    assign raw_pin[1] = raw_charger_in;
    assign raw_pin[2] = raw_misc_in;
    assign raw_pin[3] = raw_conv_ov_in;
    assign raw_pin[4] = raw_conv_uv_in;

    // address phase decode of a valid transfer
    assign a_idx  = haddr_in[ADDR_W-1:WORD_SHIFT];
    assign a_take = hsel_in && hready_in && (htrans_in == HTRANS_NONSEQ);

    // mux connection uses synchronised raw values
    generate
        for (genvar g = 0; g < NUM_REGS; g++) begin : g_conn
            assign mif.wr_val[g] = st_r.wr_val[g];
            assign mif.raw[g]    = st_r.raw_s2[g];
        end
    endgenerate
    assign mif.force_en = st_r.force_en;

    ssob_force_mux u_mux (
        .m (mif.mux)
    );

    // next state: synchronisers, writes, read data, debounce capture
    always_comb begin
        int ws;
        ws = slot_of(st_r.wr_idx);
        st_nxt = st_r;
        st_nxt.seq_s1 = seq_reset_in;
        st_nxt.seq_s2 = st_r.seq_s1;
        for (int i = 0; i < NUM_REGS; i++) begin
            st_nxt.raw_s1[i] = raw_pin[i] & mask_of(i);
            st_nxt.raw_s2[i] = st_r.raw_s1[i];
            st_nxt.deb[i]    = mif.deb[i];
        end
        // data phase of a write
        if (st_r.wr_pend) begin
            if (ws < NUM_REGS)
                st_nxt.wr_val[ws] = hwdata_in[15:0] & mask_of(ws);
            else if (st_r.wr_idx == IDX_FORCE_CTRL)
                st_nxt.force_en = hwdata_in[3:0] & MASK_FORCE_CTRL;
        end
        st_nxt.wr_pend = a_take && hwrite_in;
        st_nxt.wr_idx  = a_idx;
        // read returns raw values; unmapped reads zero
        if (a_take && !hwrite_in) begin
            if (slot_of(a_idx) < NUM_REGS)
                st_nxt.rdata = {16'h0000, st_r.raw_s2[slot_of(a_idx)]};
            else if (a_idx == IDX_FORCE_CTRL)
                st_nxt.rdata = {28'h0000000, st_r.force_en};
            else
                st_nxt.rdata = 32'h00000000;
        end
        // sequencer reset clears the regulator status bank
        if (st_r.seq_s2) begin
            st_nxt.wr_val[0] = RESET_VALUE;
            st_nxt.raw_s1[0] = RESET_VALUE;
            st_nxt.raw_s2[0] = RESET_VALUE;
        end
    end

    // state register with clock enable
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else if (clk_en_in) begin
            st_r <= st_nxt;
        end
    end

    // bus answers and debounce outputs
    assign hreadyout_out      = 1'b1;
    assign hresp_out          = HRESP_OKAY;
    assign hrdata_out         = st_r.rdata;
    assign deb_reg_status_out = st_r.deb[0];
    assign deb_charger_out    = st_r.deb[1];
    assign deb_misc_out       = st_r.deb[2];
    assign deb_conv_ov_out    = st_r.deb[3];
    assign deb_conv_uv_out    = st_r.deb[4];
endmodule

// ### test/ssob_properties.sv
// checker: bus answer and debounce input properties of the override bank
module ssob_properties
    import ssob_pkg::*;
(
    input wire logic        clk_sys_in,
    input wire logic        rst_n_in,
    input wire logic        clk_en_in,
    input wire logic        hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic        hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic        hreadyout_out,
    input wire logic [1:0]  hresp_out,
    input wire logic [15:0] raw_misc_in,
    input wire logic [15:0] deb_reg_status_out,
    input wire logic [15:0] deb_charger_out,
    input wire logic [15:0] deb_misc_out,
    input wire logic [15:0] deb_conv_ov_out,
    input wire logic [15:0] deb_conv_uv_out
);
    logic       wr_ph_r;
    logic [3:0] en_r;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    // shadow of the force control register, taken from bus writes
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ph_r <= 1'b0;
            en_r    <= 4'h0;
        end else if (clk_en_in) begin
            wr_ph_r <= hsel_in && hready_in && htrans_in == HTRANS_NONSEQ && hwrite_in && haddr_in == 32'h0000_03C0;
            if (wr_ph_r) en_r <= hwdata_in[3:0];
        end
    end
    chk_ready_high: assert property (hreadyout_out == 1'b1) else $error("slave inserted a wait state");
    chk_resp_okay: assert property (hresp_out == HRESP_OKAY) else $error("response not okay");
    chk_upper_zero: assert property (hrdata_out[31:16] == 16'h0000) else $error("upper read data set");
    chk_status_bits: assert property ((deb_reg_status_out & ~MASK_REG_STATUS) == 16'h0000) else $error("status bit");
    chk_charger_bits: assert property ((deb_charger_out & ~MASK_CHARGER) == 16'h0000) else $error("charger bit");
    chk_misc_bits: assert property ((deb_misc_out & ~MASK_MISC) == 16'h0000) else $error("misc bit");
    chk_ov_bits: assert property ((deb_conv_ov_out & ~MASK_CONV_OV) == 16'h0000) else $error("ov bit");
    chk_uv_bits: assert property ((deb_conv_uv_out & ~MASK_CONV_UV) == 16'h0000) else $error("uv bit");
    chk_misc_follow: assert property ((clk_en_in && !en_r[BIT_GENERAL_EN] && $stable(raw_misc_in))[*5]
        |-> deb_misc_out == (raw_misc_in & MASK_MISC)) else $error("misc input not following signal");
    chk_freeze_hold: assert property (!clk_en_in |=> $stable(deb_misc_out) && $stable(hrdata_out))
        else $error("state moved while clock enable low");
endmodule

// ### test/ssob_bank_tb.sv
// testbench: register access and force substitution of the override bank
module ssob_bank_tb
    import ssob_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] WV = 16'h5A5A;
    localparam logic [15:0] MSK [5] = '{MASK_REG_STATUS, MASK_CHARGER, MASK_MISC, MASK_CONV_OV, MASK_CONV_UV};
    localparam logic [15:0] PAT [2] = '{16'hFFFF, 16'hA5A5};
    localparam logic [3:0]  ENS [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hF};
    logic clk_sys_in = 1'b0, rst_n_in = 1'b0, clk_en_in = 1'b1, seq_reset_in = 1'b0, hsel_in = 1'b0, hwrite_in = 1'b0;
    logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, rd;
    logic [1:0]  htrans_in = 2'h0;
    logic [2:0]  hsize_in = 3'h2;
    logic [15:0] raw_v = 16'h0000;
    logic [15:0] deb [5];
    int          n_mismatch = 0, comparisons = 0;
    wire logic [31:0] hrdata_out;
    wire logic [1:0]  hresp_out;
    wire logic        hreadyout_out;
    wire logic        hready_in = hreadyout_out;
    wire logic [15:0] raw_reg_status_in = raw_v, raw_charger_in = raw_v, raw_misc_in = raw_v;
    wire logic [15:0] raw_conv_ov_in = raw_v, raw_conv_uv_in = raw_v;
    wire logic [15:0] deb_reg_status_out, deb_charger_out, deb_misc_out, deb_conv_ov_out, deb_conv_uv_out;
    ssob_bank dut (.*);
    // gather debounce inputs in register order
    always_comb deb = '{deb_reg_status_out, deb_charger_out, deb_misc_out, deb_conv_ov_out, deb_conv_uv_out};
    // clock
    initial forever #50 clk_sys_in = ~clk_sys_in;
    // expected debounce input for register i under enables e
    function automatic logic [15:0] exp_deb(input int i, input logic [3:0] e);
        logic [15:0] s;
        s = (i < 3) ? {16{e[0]}} : (i == 3) ? {16{e[1]}} : ({16{e[2]}} & MASK_OC_BIT) | ({16{e[3]}} & MASK_UV_BITS);
        return MSK[i] & ((WV & s) | (raw_v & ~s));
    endfunction
    // one single ahb transfer, read data left in rd
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
        @(posedge clk_sys_in);
        hsel_in <= 1'b1;
        haddr_in <= a;
        hwrite_in <= w;
        htrans_in <= HTRANS_NONSEQ;
        do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1);
        hsel_in <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= wd;
        do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1);
        rd = hrdata_out;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (4) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        xfer(1'b0, 32'h3C0, 32'h0); chk(rd, 32'h0);
        xfer(1'b0, 32'h200, 32'h0); chk(rd, 32'h0);
        for (int i = 0; i < 5; i++) xfer(1'b1, 32'h384 + 32'(4 * i), {16'h0, WV});
        foreach (PAT[p]) begin
            raw_v <= PAT[p];
            repeat (5) @(posedge clk_sys_in);
            for (int i = 0; i < 5; i++) begin
                xfer(1'b0, 32'h384 + 32'(4 * i), 32'h0); chk(rd, {16'h0, PAT[p] & MSK[i]});
                chk(deb[i], exp_deb(i, 4'h0));
            end
        end
        foreach (ENS[k]) begin
            xfer(1'b1, 32'h3C0, {28'h0, ENS[k]});
            xfer(1'b0, 32'h3C0, 32'h0); chk(rd, {28'h0, ENS[k]});
            repeat (2) @(posedge clk_sys_in);
            for (int i = 0; i < 5; i++) chk(deb[i], exp_deb(i, ENS[k]));
        end
        seq_reset_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        seq_reset_in <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        chk(deb_reg_status_out, 16'h0000);
        chk(deb_charger_out, WV & MASK_CHARGER);
        xfer(1'b1, 32'h3C0, 32'h0);
        repeat (2) @(posedge clk_sys_in);
        chk(deb_charger_out, raw_v & MASK_CHARGER);
        // low clock enable: a pin change must not reach the outputs
        clk_en_in <= 1'b0;
        raw_v <= 16'hFFFF;
        repeat (4) @(posedge clk_sys_in);
        chk(deb_misc_out, PAT[1] & MASK_MISC);
        clk_en_in <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        chk(deb_misc_out, MASK_MISC);
        // reset in mid-run clears the enables and written values
        xfer(1'b1, 32'h3C0, 32'h0000000F);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        xfer(1'b0, 32'h3C0, 32'h0); chk(rd, 32'h0);
        repeat (2) @(posedge clk_sys_in);
        chk(deb_misc_out, MASK_MISC);
        close_out;
    end
    // watchdog
    initial begin
        repeat (3000) @(posedge clk_sys_in);
        n_mismatch++;
        close_out;
    end
endmodule
bind ssob_bank ssob_properties u_chk (.*);
